//--- core/l2ram_map.vh
// Offsets, field positions, reset values and limits of the SRAM wrapper
// Included by every design file of the wrapper
`ifndef L2RAM_MAP_VH
`define L2RAM_MAP_VH
// Register offsets on the control bus
`define REG_CTRL      8'h00
`define REG_REGION_EN 8'h04
`define REG_STATUS    8'h08
`define REG_CLEAR     8'h0C
`define REG_IRQ_EN    8'h10
`define REG_ERR_ADDR  8'h14
// Field positions
`define CTRL_ECC_EN   0
`define ST_SINGLE     0
`define ST_DOUBLE     1
`define ST_ADDR       2
`define ST_INIT       3
`define ST_W          4
// Reset values
`define CTRL_RST      1'b1
`define REGION_RST    8'hFF
`define IRQ_EN_RST    4'h0
// SRAM window
`define SRAM_BASE     32'h0800_0000
`define SRAM_LAST     32'h0807_FFFF
`define REGION_CNT    8
`define SZ_DWORD      2'h3
`endif

//--- core/addr_decode.v
// One copy of the SRAM address decoder
// Assumes byte addresses and 64-bit words
`timescale 1ns/1ps
`include "l2ram_map.vh"
module addr_decode #(
  parameter IDX_W = 16
) (
  // Request address
  input  wire [31:0]      addr,
  // Decode result
  output wire             hit,
  output wire [IDX_W-1:0] idx
);
  assign hit = (addr >= `SRAM_BASE) && (addr <= `SRAM_LAST);
  assign idx = addr[IDX_W+2:3];
endmodule // addr_decode

//--- core/level2_ram_wrapper.v
// Level-two SRAM wrapper: 64-bit memory port, SECDED, init, trace
// Assumes one clock, AHB-Lite control bus, requests held until taken
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "l2ram_map.vh"
module level2_ram_wrapper #(
  parameter IDX_W = 16,
  parameter DEPTH = 65536
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Memory port
  input  wire             m_req,
  input  wire             m_write,
  input  wire [1:0]       m_size,
  input  wire [31:0]      m_addr,
  input  wire [63:0]      m_wdata,
  output reg              m_ready,
  output reg              m_done,
  output reg              m_err,
  output reg  [63:0]      m_rdata,
  // Initialization request
  input  wire             init_start,
  output reg              init_busy,
  output reg              init_done,
  // Trace port
  output reg              trc_valid,
  output reg              trc_write,
  output reg  [31:0]      trc_addr,
  output reg  [63:0]      trc_data,
  // Error events
  output reg              ev_single,
  output reg              ev_double,
  output reg              ev_addr,
  output reg              irq,
  // AHB-Lite control bus
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg  [31:0]      hrdata,
  output reg              hreadyout,
  output reg              hresp
);

  // ----------------------------------------
  // States and helpers
  // ----------------------------------------
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_READ = 2'd1;
  localparam [1:0] S_INIT = 2'd2;

  // Check byte: seven Hamming bits plus overall parity
  function [7:0] ecc_gen;
    input [63:0] d;
    integer p;
    integer j;
    integer k;
    reg [6:0] c;
    begin
      c = 7'h00;
      j = 0;
      for (p = 1; p < 72; p = p + 1)
        if ((p & (p - 1)) != 0)
        begin
          for (k = 0; k < 7; k = k + 1)
            if (p[k])
              c[k] = c[k] ^ d[j];
          j = j + 1;
        end
      ecc_gen = {^{d, c}, c};
    end
  endfunction

  // Flip the data bit that the syndrome points at
  function [63:0] ecc_fix;
    input [63:0] d;
    input [6:0]  s;
    integer p;
    integer j;
    begin
      ecc_fix = d;
      j = 0;
      for (p = 1; p < 72; p = p + 1)
        if ((p & (p - 1)) != 0)
        begin
          if (p == s)
            ecc_fix[j] = ~d[j];
          j = j + 1;
        end
    end
  endfunction

  // Byte lanes touched by a write
  function [7:0] lane_mask;
    input [1:0] sz;
    input [2:0] off;
    reg [7:0] m;
    begin
      case (sz)
        2'h0:    m = 8'h01;
        2'h1:    m = 8'h03;
        2'h2:    m = 8'h0F;
        default: m = 8'hFF;
      endcase
      lane_mask = m << off;
    end
  endfunction

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  reg [63:0]      mem_data [0:DEPTH-1];
  reg [7:0]       mem_chk  [0:DEPTH-1];
  reg [63:0]      rd_data_r;
  reg [7:0]       rd_chk_r;
  reg [1:0]       state_r;
  reg             pend_r;
  reg [IDX_W-1:0] init_idx_r;
  reg             q_write_r;
  reg [1:0]       q_size_r;
  reg [31:0]      q_addr_r;
  reg [63:0]      q_wdata_r;
  reg [IDX_W-1:0] q_idx_r;
  reg             ecc_en_r;
  reg [7:0]       region_en_r;
  reg [3:0]       status_r;
  reg [3:0]       irq_en_r;
  reg [31:0]      err_addr_r;
  reg             dp_wr_r;
  reg [7:0]       dp_addr_r;

  wire             hit_a;
  wire             hit_b;
  wire [IDX_W-1:0] idx_a;
  wire [IDX_W-1:0] idx_b;

  // ----------------------------------------
  // Duplicated address decode
  // ----------------------------------------
  // first decoder copy
  addr_decode #(.IDX_W(IDX_W)) u_dec_a (
    .addr (m_addr),
    .hit  (hit_a),
    .idx  (idx_a)
  );

  addr_decode #(.IDX_W(IDX_W)) u_dec_b (
    .addr (m_addr),
    .hit  (hit_b),
    .idx  (idx_b)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  reg             take;
  reg             mism;
  reg             dec_ok;
  reg             full;
  reg [7:0]       gen_c;
  reg [6:0]       syn;
  reg             par;
  reg             sbe;
  reg             dbe;
  reg [63:0]      fixed;
  reg [63:0]      merged;
  reg [7:0]       mask;
  reg             mem_we;
  reg [IDX_W-1:0] mem_widx;
  reg [63:0]      mem_wd;
  reg [7:0]       mem_wc;
  reg [1:0]       state_nxt;
  reg             pend_nxt;
  reg             last;
  reg [3:0]       st_set;
  reg [3:0]       st_clr;
  integer         b;

  always @*
  begin
    take   = m_req & m_ready & (state_r == S_IDLE);
    mism   = (hit_a != hit_b) | (idx_a != idx_b);
    dec_ok = hit_a & hit_b & ~mism;
    // only whole words skip the read
    full   = m_write & (m_size == `SZ_DWORD);
    gen_c  = ecc_gen(rd_data_r);
    syn    = gen_c[6:0] ^ rd_chk_r[6:0];
    par    = ^{rd_data_r, rd_chk_r};
    sbe    = (state_r == S_READ) & ecc_en_r & par;
    dbe    = (state_r == S_READ) & ecc_en_r & ~par & (syn != 7'h00);
    fixed  = sbe ? ecc_fix(rd_data_r, syn) : rd_data_r;
    mask   = lane_mask(q_size_r, q_addr_r[2:0]);
    merged = fixed;
    for (b = 0; b < 8; b = b + 1)
      if (mask[b])
        merged[b*8 +: 8] = q_wdata_r[b*8 +: 8];
    last   = (init_idx_r == DEPTH - 1);
    mem_we = (take & dec_ok & full)
           | ((state_r == S_READ) & q_write_r & ~dbe)
           | ((state_r == S_INIT) & region_en_r[init_idx_r[IDX_W-1 -: 3]]);
    case (state_r)
      S_INIT:
      begin
        mem_widx = init_idx_r;
        mem_wd   = 64'h0000_0000_0000_0000;
      end
      S_READ:
      begin
        mem_widx = q_idx_r;
        mem_wd   = merged;
      end
      default:
      begin
        mem_widx = idx_a;
        mem_wd   = m_wdata;
      end
    endcase
    // check byte for every written word
    mem_wc = ecc_gen(mem_wd);
    pend_nxt  = pend_r | init_start;
    state_nxt = state_r;
    case (state_r)
      S_IDLE:
        if (take & dec_ok & ~full)
          state_nxt = S_READ;
        else if (~take & pend_r)
        begin
          state_nxt = S_INIT;
          pend_nxt  = init_start;
        end
      S_READ:
        state_nxt = S_IDLE;
      S_INIT:
        if (last)
          state_nxt = S_IDLE;
      default:
        state_nxt = S_IDLE;
    endcase
    st_set = {(state_r == S_INIT) & last, take & mism, dbe, sbe};
    st_clr = (dp_wr_r && dp_addr_r == `REG_CLEAR) ? hwdata[`ST_W-1:0] : 4'h0;
  end

  // ----------------------------------------
  // SRAM array
  // ----------------------------------------
  // 64-bit words over the full 512 kB
  always @(posedge ref_clk)
  begin
    if (mem_we)
    begin
      mem_data[mem_widx] <= mem_wd;
      mem_chk[mem_widx]  <= mem_wc;
    end
    rd_data_r <= mem_data[idx_a];
    rd_chk_r  <= mem_chk[idx_a];
  end

  // ----------------------------------------
  // Request handling
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r    <= S_IDLE;
      pend_r     <= 1'b0;
      init_idx_r <= {IDX_W{1'b0}};
      q_write_r  <= 1'b0;
      q_size_r   <= 2'h0;
      q_addr_r   <= 32'h0000_0000;
      q_wdata_r  <= 64'h0000_0000_0000_0000;
      q_idx_r    <= {IDX_W{1'b0}};
      m_ready    <= 1'b0;
      m_done     <= 1'b0;
      m_err      <= 1'b0;
      m_rdata    <= 64'h0000_0000_0000_0000;
      init_busy  <= 1'b0;
      init_done  <= 1'b0;
      trc_valid  <= 1'b0;
      trc_write  <= 1'b0;
      trc_addr   <= 32'h0000_0000;
      trc_data   <= 64'h0000_0000_0000_0000;
      ev_single  <= 1'b0;
      ev_double  <= 1'b0;
      ev_addr    <= 1'b0;
      err_addr_r <= 32'h0000_0000;
    end
    else
    begin
      state_r   <= state_nxt;
      pend_r    <= pend_nxt;
      m_ready   <= (state_nxt == S_IDLE) & ~pend_nxt;
      init_busy <= (state_nxt == S_INIT);
      init_done <= st_set[`ST_INIT];
      m_done    <= 1'b0;
      m_err     <= 1'b0;
      trc_valid <= 1'b0;
      // one-cycle events to the error collector
      ev_single <= sbe;
      ev_double <= dbe;
      ev_addr   <= take & mism;
      if (state_r == S_INIT)
        init_idx_r <= last ? {IDX_W{1'b0}} : init_idx_r + 1'b1;
      if (take)
      begin
        q_write_r <= m_write;
        q_size_r  <= m_size;
        q_addr_r  <= m_addr;
        q_wdata_r <= m_wdata;
        q_idx_r   <= idx_a;
        if (~dec_ok | full)
        begin
          m_done <= 1'b1;
          m_err  <= ~dec_ok;
        end
        if (dec_ok & full)
        begin
          trc_valid <= 1'b1;
          trc_write <= 1'b1;
          trc_addr  <= m_addr;
          trc_data  <= m_wdata;
        end
        if (mism)
          err_addr_r <= m_addr;
      end
      if (state_r == S_READ)
      begin
        m_done  <= 1'b1;
        m_err   <= dbe;
        m_rdata <= fixed;
        // trace of reads and merged writes
        trc_valid <= ~dbe;
        trc_write <= q_write_r;
        trc_addr  <= q_addr_r;
        trc_data  <= q_write_r ? merged : fixed;
        if (sbe | dbe)
          err_addr_r <= q_addr_r;
      end
    end
  end

  // ----------------------------------------
  // Control registers and interrupt
  // ----------------------------------------
  reg [31:0] rd_val;
  reg [3:0]  status_nxt;

  always @*
  begin
    case (haddr[7:0])
      `REG_CTRL:      rd_val = {31'h0000_0000, ecc_en_r};
      `REG_REGION_EN: rd_val = {24'h00_0000, region_en_r};
      `REG_STATUS:    rd_val = {28'h000_0000, status_r};
      `REG_IRQ_EN:    rd_val = {28'h000_0000, irq_en_r};
      `REG_ERR_ADDR:  rd_val = err_addr_r;
      default:        rd_val = 32'h0000_0000;
    endcase
    // Hardware set beats software clear
    status_nxt = (status_r & ~st_clr) | st_set;
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ecc_en_r    <= `CTRL_RST;
      region_en_r <= `REGION_RST;
      status_r    <= 4'h0;
      irq_en_r    <= `IRQ_EN_RST;
      dp_wr_r     <= 1'b0;
      dp_addr_r   <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      irq         <= 1'b0;
    end
    else
    begin
      dp_wr_r   <= hsel & htrans[1] & hready & hwrite;
      dp_addr_r <= haddr[7:0];
      hrdata    <= (hsel & htrans[1] & hready & ~hwrite) ? rd_val : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      status_r  <= status_nxt;
      irq       <= |(status_nxt & irq_en_r);
      if (dp_wr_r)
        case (dp_addr_r)
          `REG_CTRL:      ecc_en_r    <= hwdata[`CTRL_ECC_EN];
          `REG_REGION_EN: region_en_r <= hwdata[`REGION_CNT-1:0];
          `REG_IRQ_EN:    irq_en_r    <= hwdata[`ST_W-1:0];
          default:        ;
        endcase
    end
  end

endmodule // level2_ram_wrapper

//--- sim/wrapper_properties.sv
// Checker for the SRAM wrapper ports
// Bound to every level2_ram_wrapper instance
`timescale 1ns/1ps
module wrapper_props (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Memory port
  input wire        m_req,
  input wire        m_write,
  input wire [1:0]  m_size,
  input wire [31:0] m_addr,
  input wire [63:0] m_wdata,
  input wire        m_ready,
  input wire        m_done,
  input wire        m_err,
  input wire [63:0] m_rdata,
  // Init, trace, events, bus
  input wire        init_busy,
  input wire        init_done,
  input wire        trc_valid,
  input wire        trc_write,
  input wire [31:0] trc_addr,
  input wire [63:0] trc_data,
  input wire        ev_double,
  input wire        hreadyout,
  input wire        hresp
);
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire tk  = m_req && m_ready;
  wire inr = m_addr[31:19] == 13'h0100;
  full_write_a: assert property (tk && inr && m_write && m_size == 2'h3
    |=> m_done && !m_err && trc_valid && trc_write && trc_data == $past(m_wdata))
    else $error("full write not done");
  read_latency_a: assert property (tk && inr && !m_write
    |=> !m_ready && !m_done ##1 m_done && trc_valid && !trc_write)
    else $error("read latency wrong");
  rmw_latency_a: assert property (tk && inr && m_write && m_size != 2'h3
    |=> !m_ready && !m_done ##1 m_done)
    else $error("narrow write latency wrong");
  range_err_a: assert property (tk && !inr |=> m_done && m_err && !trc_valid)
    else $error("outside address not refused");
  read_trace_a: assert property (trc_valid && !trc_write |-> trc_data == m_rdata)
    else $error("read trace data wrong");
  init_block_a: assert property (init_busy |-> !m_ready && !m_done)
    else $error("request taken during init");
  double_err_a: assert property (ev_double |-> m_done && m_err && !trc_valid)
    else $error("double error not refused");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("control bus not ready");
  write_addr_a: assert property (tk && inr && m_write && m_size == 2'h3
    |=> trc_addr == $past(m_addr))
    else $error("write trace address wrong");
  init_end_a: assert property (init_done |-> $past(init_busy) && !init_busy)
    else $error("init done without walk");
endmodule // wrapper_props
bind level2_ram_wrapper wrapper_props u_props (.*);

//--- sim/mem_master.sv
// Memory port master model
// Changes signals after rising edges only
`timescale 1ns/1ps
module mem_master (
  // Clock
  input  wire        ref_clk,
  // Request
  output reg         m_req = 1'b0,
  output reg         m_write = 1'b0,
  output reg  [1:0]  m_size = 2'h3,
  output reg  [31:0] m_addr = 32'h0000_0000,
  output reg  [63:0] m_wdata = 64'h0000_0000_0000_0000,
  // Answer
  input  wire        m_ready,
  input  wire        m_done,
  input  wire        m_err,
  input  wire [63:0] m_rdata
);
  // ----
  // One transfer
  // ----
  task access(input w, input [1:0] s, input [31:0] a, input [63:0] d,
              output [63:0] r, output e);
    m_req <= 1'b1;
    m_write <= w;
    m_size <= s;
    m_addr <= a;
    m_wdata <= d;
    do @(posedge ref_clk); while (!m_ready);
    // Released lines except m_size show inverted values
    m_req <= 1'b0;
    m_write <= ~w;
    m_addr <= ~a;
    m_wdata <= ~d;
    do @(posedge ref_clk); while (!m_done);
    r = m_rdata;
    e = m_err;
  endtask
endmodule // mem_master

//--- sim/testbench.sv
// Self-checking bench for the SRAM wrapper
// Drives control bus, init start and a memory master model
`timescale 1ns/1ps
`include "l2ram_map.vh"
module testbench;
  // ----
  // Signals
  // ----
  reg          ref_clk = 1'b0;
  reg          rst = 1'b1;
  reg          init_start = 1'b0;
  reg          hsel = 1'b0;
  reg          hwrite = 1'b0;
  reg   [1:0]  htrans = 2'h0;
  reg   [31:0] haddr = 32'h0000_0000;
  reg   [31:0] hwdata = 32'h0000_0000;
  wire  [2:0]  hsize = 3'h2;
  wire         hready;
  wire         m_req, m_write, m_ready, m_done, m_err, init_busy, init_done;
  wire         trc_valid, trc_write, ev_single, ev_double, ev_addr, irq;
  wire         hreadyout, hresp;
  wire  [1:0]  m_size;
  wire  [31:0] m_addr, trc_addr, hrdata;
  wire  [63:0] m_wdata, m_rdata, trc_data;
  logic [63:0] rd;
  logic [31:0] hr;
  logic        er;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  assign hready = hreadyout;
  always #2 ref_clk = ~ref_clk;
  level2_ram_wrapper #(.IDX_W(6), .DEPTH(64)) u_level2_ram_wrapper (.*);
  mem_master u_mem_master (.*);
  // ----
  // Tasks
  // ----
  task chk(input [63:0] got, input [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d = 32'h0000_0000);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge ref_clk); while (!hready);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (!hready);
    hr = hrdata;
  endtask
  task mem(input w, input [1:0] s, input [31:0] a,
           input [63:0] d = 64'h0000_0000_0000_0000);
    u_mem_master.access(w, s, a, d, rd, er);
  endtask
  task run_init;
    init_start <= 1'b1;
    @(posedge ref_clk);
    init_start <= 1'b0;
    do @(posedge ref_clk); while (!init_done);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    ahb(1'b0, `REG_CTRL);
    chk(hr, 32'h0000_0001);
    ahb(1'b0, `REG_REGION_EN);
    chk(hr, 32'h0000_00FF);
    ahb(1'b0, 8'h40);
    chk(hr, 32'h0000_0000);
    $display("test registers done");
    run_init;
    ahb(1'b0, `REG_STATUS);
    chk(hr, 32'h0000_0008);
    mem(1'b0, 2'h3, 32'h0800_01F8);
    chk(rd, 64'h0000_0000_0000_0000);
    chk(er, 1'b0);
    ahb(1'b1, `REG_IRQ_EN, 32'h0000_0008);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    ahb(1'b1, `REG_CLEAR, 32'h0000_0008);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    $display("test init done");
    mem(1'b1, 2'h3, 32'h0800_0000, 64'hA5A5_0000_FFFF_1234);
    mem(1'b1, 2'h3, 32'h0800_0040, 64'h5A5A_1111_2222_3333);
    ahb(1'b1, `REG_REGION_EN, 32'h0000_00FE);
    run_init;
    mem(1'b0, 2'h3, 32'h0800_0000);
    chk(rd, 64'hA5A5_0000_FFFF_1234);
    mem(1'b0, 2'h3, 32'h0800_0040);
    chk(rd, 64'h0000_0000_0000_0000);
    $display("test regions done");
    mem(1'b1, 2'h3, 32'h0800_0010, 64'h1111_2222_3333_4444);
    mem(1'b1, 2'h0, 32'h0800_0011, 64'hFFFF_FFFF_FFFF_ABFF);
    mem(1'b1, 2'h1, 32'h0800_0012, 64'hFFFF_FFFF_CDEF_FFFF);
    mem(1'b1, 2'h2, 32'h0800_0014, 64'h5566_7788_FFFF_FFFF);
    mem(1'b0, 2'h3, 32'h0800_0010);
    chk(rd, 64'h5566_7788_CDEF_AB44);
    ahb(1'b1, `REG_CTRL, 32'h0000_0000);
    mem(1'b1, 2'h0, 32'h0800_0017, 64'h9900_0000_0000_0000);
    ahb(1'b1, `REG_CTRL, 32'h0000_0001);
    mem(1'b0, 2'h3, 32'h0800_0010);
    chk(rd, 64'h9966_7788_CDEF_AB44);
    ahb(1'b0, `REG_STATUS);
    chk(hr, 32'h0000_0008);
    $display("test merge done");
    mem(1'b0, 2'h3, 32'h0808_0000);
    chk(er, 1'b1);
    mem(1'b1, 2'h3, 32'h07FF_FFF8, 64'h1234_5678_9ABC_DEF0);
    chk(er, 1'b1);
    $display("test range done");
    tally_and_finish;
  end
endmodule // testbench
